//--- bench/cft_core_asserts.sv
// concurrent checks on the sequencing and trap-entry ports of the core
`timescale 1ns/10ps
module cft_core_asserts
  import cft_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // issue
  input wire logic issue_valid_i,
  input wire cft_dec_s dec_i,
  input wire logic issue_ready_o,
  input wire logic nullify_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [PC_W-1:0] npc_o,
  // events and state
  input wire logic [N_EXC-1:0] exc_pend_i,
  input wire logic intr_req_i,
  input wire logic spill_fill_i,
  input wire logic [2:0] spill_fill_cwp_i,
  input wire cft_state_s state_i,
  input wire logic state_wr_o,
  input wire cft_state_s state_o,
  input wire logic [TL_W-1:0] trap_level_o,
  input wire logic trap_o,
  input wire logic [8:0] trap_type_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // plain issue that cannot trap, so only the transfer moves the counters
  wire acc = issue_valid_i && issue_ready_o && !nullify_o;
  wire go = acc && exc_pend_i == '0 && !intr_req_i && !dec_i.asr_acc;
  wire exc_go = acc && exc_pend_i != '0;
  wire [63:0] off = {{32{dec_i.disp[29]}}, dec_i.disp, 2'b00};
  wire [63:0] jt = dec_i.rs1 + (dec_i.use_imm ? {{51{dec_i.imm[12]}}, dec_i.imm} : dec_i.rs2);
  wire bcc_an = go && dec_i.kind == CT_BCC && dec_i.annul;
  chk_delay_first: assert property (go && dec_i.kind == CT_BCC && dec_i.taken && !dec_i.annul
    |=> pc_o == $past(npc_o) && npc_o == $past(pc_o) + $past(off)) else $error("delay slot not run first");
  chk_annul_cond: assert property (bcc_an && !dec_i.uncond |=> ($past(dec_i.taken) ? !nullify_o :
    (nullify_o ? pc_o == $past(npc_o) : pc_o == $past(npc_o) + INSN_BYTES))) else $error("conditional annul wrong");
  chk_annul_always: assert property (bcc_an && dec_i.uncond |=>
    (nullify_o ? pc_o == $past(npc_o) : pc_o == $past(pc_o) + $past(off))) else $error("branch-always annul wrong");
  chk_annul_quiet: assert property (issue_valid_i && issue_ready_o && nullify_o
    |=> !trap_o && trap_level_o == $past(trap_level_o)) else $error("annulled slot trapped");
  chk_indirect_tgt: assert property (go && dec_i.kind == CT_JUMP_AND_LINK |=> npc_o == $past(jt))
    else $error("indirect target wrong");
  chk_call_reach: assert property (go && dec_i.kind == CT_CALL
    |=> npc_o == $past(pc_o) + $past(off) && pc_o == $past(npc_o)) else $error("call target wrong");
  chk_trap_vector: assert property (acc && exc_pend_i[1:0] == 2'b10 |=> trap_o && trap_type_o == EXC_TT[1]
    && pc_o[14:0] == {$past(trap_level_o) != '0, EXC_TT[1], 5'h00}) else $error("trap vector wrong");
  chk_trap_save: assert property (exc_go |=> state_wr_o && state_o.condition_code_reg == $past(state_i.condition_code_reg)
    && state_o.address_space_ident == $past(state_i.address_space_ident) && (state_o.psw & PSW_TRAP_SET) == PSW_TRAP_SET
    && state_o.current_window_pointer == ($past(spill_fill_i) ? $past(spill_fill_cwp_i) : $past(state_i.current_window_pointer)))
    else $error("saved state wrong");
  chk_level_step: assert property (exc_go && trap_level_o < MAX_TL
    |=> trap_level_o == $past(trap_level_o) + 3'h1) else $error("trap level not stepped");
  cover property (trap_o);
  cover property (issue_valid_i && nullify_o);
  cover property (state_wr_o && !trap_o);
endmodule
bind cft_core cft_core_asserts u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid_i), .dec_i(dec_i),
  .issue_ready_o(issue_ready_o), .nullify_o(nullify_o), .pc_o(pc_o), .npc_o(npc_o),
  .exc_pend_i(exc_pend_i), .intr_req_i(intr_req_i), .spill_fill_i(spill_fill_i),
  .spill_fill_cwp_i(spill_fill_cwp_i), .state_i(state_i), .state_wr_o(state_wr_o), .state_o(state_o),
  .trap_level_o(trap_level_o), .trap_o(trap_o), .trap_type_o(trap_type_o)
);

//--- bench/cft_exec_model.sv
// execute-side partner: holds the live state that trap entry saves and return restores
`timescale 1ns/10ps
module cft_exec_model
  import cft_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // state update from the core
  input wire logic state_wr_i,
  input wire cft_state_s state_i,
  // live state to the core
  output cft_state_s state_o
);
  // interrupt enable set at reset, so the trap-entry clear bit is visible
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_o <= {8'h5a, 8'h80, 16'h0002, 3'h3};
    end else if (state_wr_i) begin
      state_o <= state_i;
    end
  end
endmodule

//--- bench/tb_control_flow_and_trap_entry.sv
// self-checking bench for the control-flow and trap-entry core
`timescale 1ns/10ps
module tb_control_flow_and_trap_entry;
  import cft_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, issue_valid_i = 1'b0;
  logic [7:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, err, issue_ready_o, nullify_o, state_wr_o, trap_o, irq_o;
  logic [PC_W-1:0] pc_o, npc_o;
  logic [N_EXC-1:0] exc_pend_i = '0;
  logic intr_req_i = 1'b0, spill_fill_i = 1'b0;
  logic [2:0] spill_fill_cwp_i = '0;
  logic [GL_W-1:0] gl;
  logic [TL_W-1:0] tl;
  logic [8:0] trap_type_o;
  cft_dec_s dec_i = '0, d;
  cft_state_s state_i, state_o;
  int n_mismatch = 0, checks = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  cft_core DUT (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .issue_valid_i(issue_valid_i), .dec_i(dec_i), .issue_ready_o(issue_ready_o), .nullify_o(nullify_o),
    .pc_o(pc_o), .npc_o(npc_o), .exc_pend_i(exc_pend_i), .intr_req_i(intr_req_i), .spill_fill_i(spill_fill_i),
    .spill_fill_cwp_i(spill_fill_cwp_i), .state_i(state_i), .state_wr_o(state_wr_o), .state_o(state_o),
    .global_level_selector_o(gl), .trap_level_o(tl), .trap_o(trap_o), .trap_type_o(trap_type_o), .irq_o(irq_o)
  );
  cft_exec_model u_exec (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .state_wr_i(state_wr_o), .state_i(state_o), .state_o(state_i)
  );
  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic at(input logic [63:0] p, input logic [63:0] q);
    chk("pc", p, pc_o);
    chk("npc", q, npc_o);
  endtask
  function automatic cft_dec_s mk(cft_cti_e k, logic tk, logic an, logic un, logic [29:0] ds);
    mk = '0;
    mk.kind = k;
    mk.taken = tk;
    mk.annul = an;
    mk.uncond = un;
    mk.disp = ds;
  endfunction
  // one apb transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk_i);
      if (pready_o === 1'b1) break;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n == 20) begin
      n_mismatch++;
      finish_test();
    end
    #1;
  endtask
  // ready is combinational from registers, so it is settled 1 ns after each edge
  task automatic iss(input cft_dec_s x);
    int n;
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b1;
    dec_i <= x;
    #1;
    for (n = 0; n < 20 && issue_ready_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (n == 20) begin
      n_mismatch++;
      finish_test();
    end
    @(posedge ref_clk_i);
    issue_valid_i <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    #1;
    at(64'h20, 64'h24);
    chk("pready", 1'b1, pready_o);
    iss(mk(CT_BCC, 1'b1, 1'b0, 1'b0, 30'h4));
    at(64'h24, 64'h30);
    iss('0);
    at(64'h30, 64'h34);
    iss(mk(CT_BCC, 1'b0, 1'b1, 1'b0, 30'h4));
    chk("nullify", 1'b1, nullify_o);
    at(64'h34, 64'h38);
    exc_pend_i <= 8'h01;
    iss('0);
    exc_pend_i <= '0;
    chk("trap", 1'b0, trap_o);
    at(64'h38, 64'h3c);
    iss(mk(CT_BCC, 1'b1, 1'b1, 1'b1, 30'h3ffffffe));
    chk("nullify", 1'b1, nullify_o);
    at(64'h3c, 64'h30);
    iss('0);
    at(64'h30, 64'h34);
    iss(mk(CT_CALL, 1'b1, 1'b0, 1'b0, 30'h3ffffffc));
    at(64'h34, 64'h20);
    d = mk(CT_JUMP_AND_LINK, 1'b1, 1'b0, 1'b0, 30'h0);
    d.rs1 = 64'h100;
    d.imm = 13'h1ff8;
    d.use_imm = 1'b1;
    iss(d);
    // the jump sits in the call's delay slot, so pc takes the call target
    at(64'h20, 64'hf8);
    iss('0);
    apb(1'b1, OFS_TBA_LO, 32'h0001_0000);
    apb(1'b1, OFS_TBA_HI, 32'h0);
    apb(1'b1, OFS_MASK, 32'hf);
    exc_pend_i <= 8'h0a;
    iss('0);
    exc_pend_i <= '0;
    at(64'h10140, 64'h10144);
    chk("tt", 9'h00a, trap_type_o);
    chk("state", {1'b1, 8'h5a, 8'h80, 16'h0004, 3'h3}, {state_wr_o, state_o});
    chk("levels", {3'h1, 2'h1}, {tl, gl});
    spill_fill_i <= 1'b1;
    spill_fill_cwp_i <= 3'h5;
    d = mk(CT_TCC, 1'b1, 1'b0, 1'b0, 30'h0);
    d.imm = 13'h5;
    iss(d);
    spill_fill_i <= 1'b0;
    at(64'h160a0, 64'h160a4);
    chk("tt", 9'h105, trap_type_o);
    chk("state", {8'h5a, 8'h80, 16'h0004, 3'h5}, state_o);
    iss(mk(CT_RETRY, 1'b1, 1'b0, 1'b0, 30'h0));
    chk("ready", 1'b0, issue_ready_o);
    @(posedge ref_clk_i);
    #1;
    at(64'h10140, 64'h10144);
    chk("restore", {1'b1, 8'h5a, 8'h80, 16'h0004, 3'h3}, {state_wr_o, state_o});
    iss(mk(CT_DONE, 1'b1, 1'b0, 1'b0, 30'h0));
    @(posedge ref_clk_i);
    #1;
    at(64'hfc, 64'h100);
    chk("levels", 5'h0, {tl, gl});
    d = '0;
    d.asr_acc = 1'b1;
    iss(d);
    at(64'h100, 64'h104);
    d.asr_num = 5'h01;
    // interrupt enabled again after the return, but the illegal access outranks it
    intr_req_i <= 1'b1;
    iss(d);
    intr_req_i <= 1'b0;
    at(64'h10200, 64'h10204);
    chk("tt", ILLEGAL_TT, trap_type_o);
    chk("irq", 1'b1, irq_o);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h7, rd);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    chk("irq", 1'b0, irq_o);
    apb(1'b0, OFS_LEVEL, 32'h0);
    chk("level", 32'h11, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 33'h1_0000_0000, {err, rd});
    apb(1'b1, OFS_CTRL, 32'h1);
    iss(mk(CT_BCC, 1'b0, 1'b1, 1'b0, 30'h4));
    chk("nullify", 1'b0, nullify_o);
    at(64'h10208, 64'h1020c);
    iss(mk(CT_BCC, 1'b1, 1'b1, 1'b1, 30'h4));
    at(64'h10218, 64'h1021c);
    iss(mk(CT_BPR, 1'b1, 1'b0, 1'b0, 30'h8000));
    at(64'h1021c, 64'hffff_ffff_ffff_0218);
    finish_test();
  end
endmodule

//--- design/cft_core.sv
// program-counter sequencing, delay-slot annulment and trap entry with apb control
// Contract
// - a taken delayed transfer still runs the delay instruction before the target
// - annul bit on conditional transfer nullifies delay slot only when not taken
// - annul bit on branch-always nullifies the delay slot every time
// - an annulled delay slot may be skipped instead of fetched
// - register-indirect target is rs1 plus rs2 or sign-extended 13-bit immediate
// - branch and call targets are pc-relative; register branch reaches 128 KB
// - call uses a 30-bit word displacement reaching two gigabytes either way
// - done and retry take targets from the saved trap counters of current level
// - trap entry saves pc and next pc into the trap stack
// - trap entry saves condition codes, asi, state word and window pointer
// - trap stack has exactly one entry per supported trap level
// - trap entry sets state word bits and increments global level selector
// - window pointer unchanged on trap except spill or fill names target window
// - pending exceptions and interrupts checked before each instruction, highest wins
// - vector is table base plus displacement from trap type and level
// - hardware traps and software trap instructions use separate table regions
// - undefined ancillary state registers 0 to 27 are reserved
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module cft_core
  import cft_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // decode/execute issue
  input wire logic issue_valid_i,
  input wire cft_dec_s dec_i,
  output logic issue_ready_o,
  output logic nullify_o,
  output logic [PC_W-1:0] pc_o,
  output logic [PC_W-1:0] npc_o,
  // pending events
  input wire logic [N_EXC-1:0] exc_pend_i,
  input wire logic intr_req_i,
  input wire logic spill_fill_i,
  input wire logic [2:0] spill_fill_cwp_i,
  // state registers
  input wire cft_state_s state_i,
  output logic state_wr_o,
  output cft_state_s state_o,
  output logic [GL_W-1:0] global_level_selector_o,
  output logic [TL_W-1:0] trap_level_o,
  output logic trap_o,
  output logic [8:0] trap_type_o,
  // interrupt
  output logic irq_o
);
  typedef enum logic [0:0] {S_RUN, S_RET} cft_state_e;

  cft_state_e fsm_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] next_prog_counter_reg;
  logic annul_reg;
  logic ret_retry_reg;
  logic [TL_W-1:0] tl_reg;
  logic [GL_W-1:0] gl_reg;
  logic [PC_W-1:0] trap_table_base_reg;
  logic skip_reg;
  logic [N_EV-1:0] status_reg;
  logic [N_EV-1:0] mask_reg;
  logic [8:0] last_tt_reg;
  logic [31:0] prdata_reg;
  logic trap_reg;
  logic state_wr_reg;
  cft_state_s state_out_reg;

  logic fire;
  logic live;
  logic is_branch;
  logic annul_slot;
  logic [PC_W-1:0] disp_sx;
  logic [PC_W-1:0] imm_sx;
  logic [PC_W-1:0] rel_target;
  logic [PC_W-1:0] ind_target;
  logic asr_bad;
  logic ret_bad;
  logic intr_ok;
  logic tcc_take;
  logic trap_take;
  logic [8:0] tt_sel;
  logic [PC_W-1:0] vector;
  cft_entry_s push_entry;
  cft_entry_s top_entry;
  logic [TL_W-1:0] top_addr;
  logic [N_EV-1:0] ev;
  logic apb_done;
  logic setup;

  assign issue_ready_o = (fsm_reg == S_RUN);
  assign fire = issue_valid_i && issue_ready_o;
  assign live = fire && !annul_reg;
  assign is_branch = (dec_i.kind == CT_BCC) || (dec_i.kind == CT_BPCC) || (dec_i.kind == CT_BPR);
  assign annul_slot = is_branch && dec_i.annul && (dec_i.uncond || !dec_i.taken);

  always_comb begin
    unique case (dec_i.kind)
      CT_BCC: disp_sx = {{40{dec_i.disp[21]}}, dec_i.disp[21:0], 2'b00};
      CT_BPCC: disp_sx = {{43{dec_i.disp[18]}}, dec_i.disp[18:0], 2'b00};
      CT_BPR: disp_sx = {{46{dec_i.disp[15]}}, dec_i.disp[15:0], 2'b00};
      CT_CALL: disp_sx = {{32{dec_i.disp[29]}}, dec_i.disp[29:0], 2'b00};
      default: disp_sx = '0;
    endcase
  end
  assign rel_target = pc_reg + disp_sx;

  assign imm_sx = {{51{dec_i.imm[12]}}, dec_i.imm};
  assign ind_target = dec_i.rs1 + (dec_i.use_imm ? imm_sx : dec_i.rs2);

  // reserved ancillary numbers trap as illegal
  assign asr_bad = dec_i.asr_acc && (dec_i.asr_num < ASR_IMPL_FIRST) && !ASR_DEFINED[dec_i.asr_num];
  // return with an empty stack has nothing to return to
  assign ret_bad = ((dec_i.kind == CT_DONE) || (dec_i.kind == CT_RETRY)) && (tl_reg == '0);
  assign intr_ok = intr_req_i && state_i.psw[PSW_IE_BIT];
  assign tcc_take = (dec_i.kind == CT_TCC) && dec_i.taken;

  // priority select, lowest exception index wins
  always_comb begin
    tt_sel = '0;
    trap_take = 1'b0;
    if (intr_ok) begin
      tt_sel = INTR_TT;
      trap_take = 1'b1;
    end
    if (tcc_take) begin
      tt_sel = SW_TT_BASE | {2'b00, dec_i.imm[6:0]};
      trap_take = 1'b1;
    end
    if (asr_bad || ret_bad) begin
      tt_sel = ILLEGAL_TT;
      trap_take = 1'b1;
    end
    for (int i = N_EXC - 1; i >= 0; i--) begin
      if (exc_pend_i[i]) begin
        tt_sel = EXC_TT[i];
        trap_take = 1'b1;
      end
    end
  end

  // base plus type and level displacement
  assign vector = {trap_table_base_reg[PC_W-1:TBA_LSB], (tl_reg != '0), tt_sel, 5'h00};

  assign push_entry.saved_trap_prog_counter = pc_reg;
  assign push_entry.saved_trap_next_counter = next_prog_counter_reg;
  assign push_entry.saved_trap_state = state_i;
  assign top_addr = (tl_reg == '0) ? '0 : tl_reg - TL_W'(1);

  cft_stack_mem u_stack (
    .ref_clk_i (ref_clk_i),
    .wr_en_i (live && trap_take && (tl_reg < MAX_TL)),
    .wr_addr_i (tl_reg),
    .wr_data_i (push_entry),
    .rd_addr_i (top_addr),
    .rd_data_o (top_entry)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      fsm_reg <= S_RUN;
      ret_retry_reg <= 1'b0;
    end else if (fsm_reg == S_RET) begin
      fsm_reg <= S_RUN;
    end else if (live && !trap_take && ((dec_i.kind == CT_DONE) || (dec_i.kind == CT_RETRY))) begin
      // stack read data is registered, so wait one cycle for the top entry
      fsm_reg <= S_RET;
      ret_retry_reg <= (dec_i.kind == CT_RETRY);
    end
  end

  // program counter sequencing
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pc_reg <= RESET_PC;
      next_prog_counter_reg <= RESET_PC + INSN_BYTES;
      annul_reg <= 1'b0;
    end else if (fsm_reg == S_RET) begin
      pc_reg <= ret_retry_reg ? top_entry.saved_trap_prog_counter : top_entry.saved_trap_next_counter;
      next_prog_counter_reg <= ret_retry_reg ? top_entry.saved_trap_next_counter : top_entry.saved_trap_next_counter + INSN_BYTES;
    end else if (fire) begin
      annul_reg <= 1'b0;
      if (annul_reg) begin
        pc_reg <= next_prog_counter_reg;
        next_prog_counter_reg <= next_prog_counter_reg + INSN_BYTES;
      end else if (trap_take) begin
        pc_reg <= vector;
        next_prog_counter_reg <= vector + INSN_BYTES;
      end else if (annul_slot && skip_reg) begin
        pc_reg <= dec_i.taken ? rel_target : next_prog_counter_reg + INSN_BYTES;
        next_prog_counter_reg <= (dec_i.taken ? rel_target : next_prog_counter_reg + INSN_BYTES) + INSN_BYTES;
      end else begin
        pc_reg <= next_prog_counter_reg;
        annul_reg <= annul_slot;
        unique case (dec_i.kind)
          CT_BCC, CT_BPCC, CT_BPR: begin
            next_prog_counter_reg <= dec_i.taken ? rel_target : next_prog_counter_reg + INSN_BYTES;
          end
          CT_CALL: next_prog_counter_reg <= rel_target;
          CT_JUMP_AND_LINK, CT_RETURN: next_prog_counter_reg <= ind_target;
          default: next_prog_counter_reg <= next_prog_counter_reg + INSN_BYTES;
        endcase
      end
    end
  end

  // trap and global levels
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tl_reg <= '0;
      gl_reg <= '0;
    end else if (fsm_reg == S_RET) begin
      tl_reg <= tl_reg - TL_W'(1);
      if (gl_reg != '0) begin
        gl_reg <= gl_reg - GL_W'(1);
      end
    end else if (live && trap_take) begin
      if (tl_reg < MAX_TL) begin
        tl_reg <= tl_reg + TL_W'(1);
      end
      if (gl_reg < MAX_GL) begin
        gl_reg <= gl_reg + GL_W'(1);
      end
    end
  end

  // state word updates toward the state registers
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_wr_reg <= 1'b0;
      state_out_reg <= '0;
      trap_reg <= 1'b0;
      last_tt_reg <= '0;
    end else begin
      state_wr_reg <= 1'b0;
      trap_reg <= 1'b0;
      if (fsm_reg == S_RET) begin
        state_wr_reg <= 1'b1;
        state_out_reg <= top_entry.saved_trap_state;
      end else if (live && trap_take) begin
        state_wr_reg <= 1'b1;
        trap_reg <= 1'b1;
        last_tt_reg <= tt_sel;
        state_out_reg <= state_i;
        // force trap bits in state word
        state_out_reg.psw <= (state_i.psw | PSW_TRAP_SET) & ~PSW_TRAP_CLR;
        // window moves only for spill or fill
        state_out_reg.current_window_pointer <= spill_fill_i ? spill_fill_cwp_i : state_i.current_window_pointer;
      end
    end
  end

  assign ev[EV_TRAP] = live && trap_take;
  assign ev[EV_RET] = (fsm_reg == S_RET);
  assign ev[EV_RSV_ASR] = live && asr_bad;
  assign ev[EV_TL_MAX] = live && trap_take && (tl_reg >= MAX_TL);

  // apb slave: read data captured in setup, zero wait in access
  assign setup = psel_i && !penable_i;
  assign apb_done = psel_i && penable_i;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      prdata_reg <= '0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= 1'b0;
      prdata_reg <= '0;
      unique case (paddr_i)
        OFS_CTRL: prdata_reg <= {31'h0, skip_reg};
        OFS_TBA_LO: prdata_reg <= trap_table_base_reg[31:0];
        OFS_TBA_HI: prdata_reg <= trap_table_base_reg[63:32];
        OFS_STATUS: prdata_reg <= {28'h0, status_reg};
        OFS_MASK: prdata_reg <= {28'h0, mask_reg};
        OFS_LEVEL: prdata_reg <= {24'h0, 1'b0, tl_reg, 2'b00, gl_reg};
        OFS_PC_LO: prdata_reg <= pc_reg[31:0];
        OFS_PC_HI: prdata_reg <= pc_reg[63:32];
        OFS_LAST_TT: prdata_reg <= {23'h0, last_tt_reg};
        default: pslverr_o <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      skip_reg <= 1'b0;
      trap_table_base_reg <= '0;
      mask_reg <= '0;
    end else if (apb_done && pwrite_i) begin
      unique case (paddr_i)
        OFS_CTRL: skip_reg <= pwdata_i[CTRL_SKIP_BIT];
        OFS_TBA_LO: trap_table_base_reg[31:0] <= pwdata_i;
        OFS_TBA_HI: trap_table_base_reg[63:32] <= pwdata_i;
        OFS_MASK: mask_reg <= pwdata_i[N_EV-1:0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // only bits reported in the captured read are cleared, so a late event survives
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      status_reg <= '0;
    end else if (apb_done && !pwrite_i && (paddr_i == OFS_STATUS)) begin
      status_reg <= (status_reg & ~prdata_reg[N_EV-1:0]) | ev;
    end else begin
      status_reg <= status_reg | ev;
    end
  end

  assign pready_o = 1'b1;
  assign prdata_o = prdata_reg;
  assign irq_o = |(status_reg & mask_reg);
  assign nullify_o = annul_reg;
  assign pc_o = pc_reg;
  assign npc_o = next_prog_counter_reg;
  assign state_wr_o = state_wr_reg;
  assign state_o = state_out_reg;
  assign global_level_selector_o = gl_reg;
  assign trap_level_o = tl_reg;
  assign trap_o = trap_reg;
  assign trap_type_o = last_tt_reg;
endmodule

//--- design/cft_pkg.sv
// shared constants and carrier types for the control-flow and trap-entry block
package cft_pkg;
  localparam int PC_W = 64;
  localparam int TL_W = 3;
  localparam int GL_W = 2;
  localparam logic [TL_W-1:0] MAX_TL = 3'h6;
  localparam logic [GL_W-1:0] MAX_GL = 2'h3;
  localparam int STACK_DEPTH = 6;
  localparam logic [PC_W-1:0] RESET_PC = 64'h0000_0000_0000_0020;
  localparam logic [PC_W-1:0] INSN_BYTES = 64'h4;
  // processor state word bits forced on trap entry
  localparam logic [15:0] PSW_TRAP_SET = 16'h0004;
  localparam logic [15:0] PSW_TRAP_CLR = 16'h0002;
  localparam int PSW_IE_BIT = 1;
  // trap table layout
  localparam int TBA_LSB = 15;
  localparam int VEC_ENTRY_SHIFT = 5;
  localparam logic [8:0] SW_TT_BASE = 9'h100;
  localparam logic [8:0] ILLEGAL_TT = 9'h010;
  localparam logic [8:0] INTR_TT = 9'h041;
  localparam int N_EXC = 8;
  localparam logic [8:0] EXC_TT [N_EXC] = '{9'h008, 9'h00a, 9'h020, 9'h024,
                                            9'h028, 9'h030, 9'h080, 9'h0c0};
  // ancillary state register numbers below this are architectural
  localparam logic [4:0] ASR_IMPL_FIRST = 5'h1c;
  localparam logic [27:0] ASR_DEFINED = 28'h0100_003d;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TBA_LO = 8'h04;
  localparam logic [7:0] OFS_TBA_HI = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_LEVEL = 8'h14;
  localparam logic [7:0] OFS_PC_LO = 8'h18;
  localparam logic [7:0] OFS_PC_HI = 8'h1c;
  localparam logic [7:0] OFS_LAST_TT = 8'h20;
  localparam int CTRL_SKIP_BIT = 0;
  localparam int N_EV = 4;
  localparam int EV_TRAP = 0;
  localparam int EV_RET = 1;
  localparam int EV_RSV_ASR = 2;
  localparam int EV_TL_MAX = 3;

  typedef enum logic [3:0] {
    CT_NONE, CT_BCC, CT_BPCC, CT_BPR, CT_CALL, CT_JUMP_AND_LINK, CT_RETURN, CT_DONE, CT_RETRY, CT_TCC
  } cft_cti_e;

  typedef struct packed {
    cft_cti_e kind;
    logic uncond;
    logic annul;
    logic taken;
    logic [29:0] disp;
    logic [63:0] rs1;
    logic [63:0] rs2;
    logic [12:0] imm;
    logic use_imm;
    logic asr_acc;
    logic [4:0] asr_num;
  } cft_dec_s;

  typedef struct packed {
    logic [7:0] condition_code_reg;
    logic [7:0] address_space_ident;
    logic [15:0] psw;
    logic [2:0] current_window_pointer;
  } cft_state_s;

  typedef struct packed {
    logic [PC_W-1:0] saved_trap_prog_counter;
    logic [PC_W-1:0] saved_trap_next_counter;
    cft_state_s saved_trap_state;
  } cft_entry_s;
endpackage

//--- design/cft_stack_mem.sv
// hardware trap stack: one entry per trap level, registered read
`timescale 1ns/10ps
module cft_stack_mem
  import cft_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [TL_W-1:0] wr_addr_i,
  input wire cft_entry_s wr_data_i,
  // read side
  input wire logic [TL_W-1:0] rd_addr_i,
  output cft_entry_s rd_data_o
);
  cft_entry_s mem [STACK_DEPTH];

  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i && (wr_addr_i < TL_W'(STACK_DEPTH))) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // out-of-range reads return zero rather than an undefined word
  always_ff @(posedge ref_clk_i) begin
    if (rd_addr_i < TL_W'(STACK_DEPTH)) begin
      rd_data_o <= mem[rd_addr_i];
    end else begin
      rd_data_o <= '0;
    end
  end
endmodule
